// File: core/drm_oneshot.v
// Retriggerable-proof ring threshold one-shot with a fixed-length timeout.
// Assumes a synchronised threshold input on the pclk domain.
`timescale 1ns/1ps
`include "drm_defines.vh"

module drm_oneshot #(
	parameter CNT_W = 28,
	parameter [CNT_W-1:0] LENGTH = `DRM_ONESHOT_CYC
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Trigger and pulse
	input wire trigger,
	output reg pulse,
	output reg expired
);
	reg [CNT_W-1:0] count; // Cycles left in the pulse
	reg trigger_d; // Previous trigger, for edge detection

	// ------------------------------------------------------------------------
	// Pulse timer
	// ------------------------------------------------------------------------
	// Starts on a rising crossing, ignores further crossings until timeout
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= {CNT_W{1'b0}};
			pulse <= 1'b0;
			trigger_d <= 1'b0;
			expired <= 1'b0;
		end else begin
			trigger_d <= trigger;
			expired <= 1'b0;
			if (pulse) begin
				// Only the counter ends the pulse
				if (count == {{(CNT_W-1){1'b0}}, 1'b1}) begin
					pulse <= 1'b0;
					expired <= 1'b1;
				end
				count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
			end else if (trigger && !trigger_d) begin
				pulse <= 1'b1; // Unqualified start at threshold
				count <= LENGTH;
			end
		end
	end
endmodule // drm_oneshot

// File: core/drm_regs.v
// APB register bank: ring detector mode, dropout status and call-progress
// monitor levels, with ring-detect selection and monitor mixing.
// Assumes all inputs from the analog side are asynchronous to pclk.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "drm_defines.vh"

module drm_regs #(
	parameter SAMPLE_W = 16,
	parameter CNT_W = 28,
	parameter [CNT_W-1:0] ONESHOT_CYCLES = `DRM_ONESHOT_CYC
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`DRM_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Analog side indications (asynchronous)
	input wire ring_halfwave_in,
	input wire ring_fullwave_in,
	input wire ring_envelope_in,
	input wire ring_threshold_in,
	input wire line_dropout_in,
	// Monitor samples (pclk domain, signed)
	input wire [SAMPLE_W-1:0] rx_sample,
	input wire [SAMPLE_W-1:0] tx_sample,
	// Outputs
	output reg ring_detect_flag,
	output reg ring_fullwave_select,
	output reg [SAMPLE_W-1:0] call_progress_output,
	output wire irq
);
	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	// Linear scale: code 0x40 is unity, so product shifted by six
	function [SAMPLE_W+1:0] mon_scale;
		input [SAMPLE_W-1:0] s;
		input [7:0] code;
		reg signed [SAMPLE_W+8:0] prod;
		begin
			prod = $signed(s) * $signed({1'b0, code});
			mon_scale = prod[SAMPLE_W+7:6];
		end
	endfunction

	// Register byte address match
	function addr_is;
		input [`DRM_ADDR_W-1:0] a;
		input [7:0] idx;
		begin
			addr_is = (a == {{(`DRM_ADDR_W-10){1'b0}}, idx, 2'b00});
		end
	endfunction

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	reg [7:0] monitor_rx_level; // Receive path monitor level
	reg [7:0] monitor_tx_level; // Transmit path monitor level
	reg ring_validation_enable; // Control bit of an added register
	reg line_dropout_flag; // Synchronised dropout status
	reg [`DRM_IRQ_W-1:0] irq_status; // Sticky event bits
	reg [`DRM_IRQ_W-1:0] irq_mask; // Enable per event bit
	reg [4:0] sync1; // First synchroniser stage
	reg [4:0] sync2; // Second synchroniser stage
	reg ring_flag_d; // Previous flag for edge event
	reg drop_d; // Previous dropout for edge event
	wire shot_pulse; // One-shot output
	wire shot_expired; // One-shot timeout strobe
	wire wr_en; // Write access phase
	wire [SAMPLE_W+2:0] mix; // Sum of both scaled paths
	wire [SAMPLE_W+1:0] rx_scaled; // Receive path after its level
	wire [SAMPLE_W+1:0] tx_scaled; // Transmit path after its level
	reg next_ring_flag; // Selected ring indication
	reg [`DRM_IRQ_W-1:0] next_irq_status; // Status after set and clear

	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1; // Zero wait states
	assign pslverr = 1'b0; // Unmapped reads return zero, writes ignored
	assign irq = |(irq_status & irq_mask);

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	// Two flops per asynchronous line; only sync2 is read downstream
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end else begin
			sync1 <= {line_dropout_in, ring_threshold_in, ring_envelope_in,
				ring_fullwave_in, ring_halfwave_in};
			sync2 <= sync1;
		end
	end

	// ------------------------------------------------------------------------
	// Threshold one-shot
	// ------------------------------------------------------------------------
	drm_oneshot #(
		.CNT_W(CNT_W),
		.LENGTH(ONESHOT_CYCLES)
	) u_oneshot (
		.pclk(pclk),
		.presetn(presetn),
		.trigger(sync2[3]),
		.pulse(shot_pulse),
		.expired(shot_expired)
	);

	// ------------------------------------------------------------------------
	// Ring-detect source selection
	// ------------------------------------------------------------------------
	always @* begin
		case ({ring_validation_enable, ring_fullwave_select})
		2'b00: next_ring_flag = sync2[0]; // Half-wave rectifier
		2'b01: next_ring_flag = sync2[1]; // Full-wave rectifier
		2'b10: next_ring_flag = sync2[2]; // Validated envelope
		2'b11: next_ring_flag = shot_pulse; // Unqualified one-shot
		default: next_ring_flag = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// Status flags and sticky events
	// ------------------------------------------------------------------------
	// Hardware set beats a same-cycle write-one-to-clear
	always @* begin
		next_irq_status = irq_status;
		if (wr_en && addr_is(paddr, `DRM_IDX_IRQ_STATUS)) begin
			next_irq_status = irq_status & ~pwdata[`DRM_IRQ_W-1:0];
		end
		if (next_ring_flag && !ring_flag_d) begin
			next_irq_status[`DRM_IRQ_RING] = 1'b1;
		end
		if (sync2[4] && !drop_d) begin
			next_irq_status[`DRM_IRQ_DROP] = 1'b1;
		end
		if (shot_expired) begin
			next_irq_status[`DRM_IRQ_SHOT] = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_detect_flag <= 1'b0;
			ring_flag_d <= 1'b0;
			line_dropout_flag <= 1'b0;
			drop_d <= 1'b0;
			irq_status <= {`DRM_IRQ_W{1'b0}};
		end else begin
			ring_detect_flag <= next_ring_flag;
			ring_flag_d <= next_ring_flag;
			line_dropout_flag <= sync2[4]; // Status only, no write path
			drop_d <= sync2[4];
			irq_status <= next_irq_status;
		end
	end

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// Each register written alone; others untouched
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_fullwave_select <= `DRM_RST_FULLWAVE;
			monitor_rx_level <= {`DRM_RST_MON_HI, `DRM_RST_MON_LO};
			monitor_tx_level <= `DRM_RST_MON_TX;
			ring_validation_enable <= `DRM_RST_CTRL;
			irq_mask <= `DRM_RST_MASK;
		end else if (wr_en) begin
			if (addr_is(paddr, `DRM_IDX_RING_MODE)) begin
				ring_fullwave_select <= pwdata[`DRM_BIT_FULLWAVE];
			end
			if (addr_is(paddr, `DRM_IDX_MON_RX)) begin
				monitor_rx_level <= pwdata[7:0];
			end
			if (addr_is(paddr, `DRM_IDX_MON_TX)) begin
				monitor_tx_level <= pwdata[7:0];
			end
			if (addr_is(paddr, `DRM_IDX_CTRL)) begin
				ring_validation_enable <= pwdata[`DRM_BIT_VALID_EN];
			end
			if (addr_is(paddr, `DRM_IDX_IRQ_MASK)) begin
				irq_mask <= pwdata[`DRM_IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------------
	// Reserved bits read zero; software must not rely on them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h00000000;
			if (addr_is(paddr, `DRM_IDX_RING_MODE)) begin
				prdata[`DRM_BIT_FULLWAVE] <= ring_fullwave_select;
			end
			if (addr_is(paddr, `DRM_IDX_DROPOUT)) begin
				prdata[`DRM_BIT_DROPOUT] <= line_dropout_flag;
			end
			if (addr_is(paddr, `DRM_IDX_MON_RX)) begin
				prdata[7:0] <= monitor_rx_level;
			end
			if (addr_is(paddr, `DRM_IDX_MON_TX)) begin
				prdata[7:0] <= monitor_tx_level;
			end
			if (addr_is(paddr, `DRM_IDX_CTRL)) begin
				prdata[`DRM_BIT_VALID_EN] <= ring_validation_enable;
			end
			if (addr_is(paddr, `DRM_IDX_IRQ_STATUS)) begin
				prdata[`DRM_IRQ_W-1:0] <= irq_status;
			end
			if (addr_is(paddr, `DRM_IDX_IRQ_MASK)) begin
				prdata[`DRM_IRQ_W-1:0] <= irq_mask;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Call-progress monitor mix
	// ------------------------------------------------------------------------
	// Code zero gives a zero product, so each path mutes alone
	assign rx_scaled = mon_scale(rx_sample, monitor_rx_level);
	assign tx_scaled = mon_scale(tx_sample, monitor_tx_level);
	// Sign-extend each path by one bit so the sum cannot wrap
	assign mix = {rx_scaled[SAMPLE_W+1], rx_scaled}
		+ {tx_scaled[SAMPLE_W+1], tx_scaled};

	// Saturate rather than wrap: a wrap is a loud click on the monitor
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			call_progress_output <= {SAMPLE_W{1'b0}};
		end else if (mix[SAMPLE_W+2] != mix[SAMPLE_W-1] ||
			mix[SAMPLE_W+1] != mix[SAMPLE_W-1] ||
			mix[SAMPLE_W] != mix[SAMPLE_W-1]) begin
			call_progress_output <= {mix[SAMPLE_W+2], {(SAMPLE_W-1){~mix[SAMPLE_W+2]}}};
		end else begin
			call_progress_output <= mix[SAMPLE_W-1:0]; // Next sample uses new level
		end
	end
endmodule // drm_regs

// File: pkg/drm_defines.vh
// Register offsets, field positions, reset values and timing counts for the
// line-side ring mode, dropout and call-progress monitor register bank.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef DRM_DEFINES_VH
`define DRM_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------------
`define DRM_IDX_RING_MODE 8'h12
`define DRM_IDX_DROPOUT 8'h13
`define DRM_IDX_MON_RX 8'h14
`define DRM_IDX_MON_TX 8'h15
`define DRM_IDX_CTRL 8'h16
`define DRM_IDX_IRQ_STATUS 8'h17
`define DRM_IDX_IRQ_MASK 8'h18
`define DRM_ADDR_W 12

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define DRM_BIT_FULLWAVE 1
`define DRM_BIT_DROPOUT 1
`define DRM_BIT_VALID_EN 0
`define DRM_RST_FULLWAVE 1'b0
`define DRM_RST_MON_LO 4'h0
`define DRM_RST_MON_HI 4'h4
`define DRM_RST_MON_TX 8'h40
`define DRM_RST_CTRL 1'b0
`define DRM_RST_MASK 3'h0
`define DRM_IRQ_RING 0
`define DRM_IRQ_DROP 1
`define DRM_IRQ_SHOT 2
`define DRM_IRQ_W 3

// ----------------------------------------------------------------------------
// Timing: one-shot length
// ----------------------------------------------------------------------------
`define DRM_CLK_HZ 50000000
`define DRM_ONESHOT_S 5
// Five seconds at 50 MHz, sized to the 28-bit one-shot counter
`define DRM_ONESHOT_CYC 28'd250000000

`endif

// File: testbench/drm_host_model.sv
// Host model: APB master in place of the system-side module and software.
// Assumes pclk from the bench; one transfer at a time.
`timescale 1ns/1ps
module drm_host_model (
	// Clock
	input wire pclk,
	// APB master
	output reg psel = 1'b0,
	output reg penable = 1'b0,
	output reg pwrite = 1'b0,
	output reg [11:0] paddr = 12'h0,
	output reg [31:0] pwdata = 32'h0,
	input wire pready,
	input wire [31:0] prdata
);
	// ------
	// Transfer: setup, access until pready, then release
	// ------
	task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d; // Callers keep reserved bits zero
			@(posedge pclk);
			penable <= 1'b1;
			// Wait as long as the slave needs; only the bench watchdog ends a hang
			do begin
				@(posedge pclk);
			end while (!pready);
			q = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			// Released data must not look like the last value
			pwdata <= ~d;
		end
	endtask
endmodule // drm_host_model

// File: testbench/drm_regs_properties.sv
// Checker for the ring mode, dropout and monitor register bank.
// Bound to drm_regs below; it sees only that module's ports.
`timescale 1ns/1ps
module drm_regs_chk #(
	parameter SAMPLE_W = 16
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave side
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	// Line side
	input wire line_dropout_in,
	input wire ring_detect_flag,
	input wire ring_fullwave_select,
	input wire [SAMPLE_W-1:0] call_progress_output
);
	// ------
	// Steps
	// ------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup cycle of a read
	sequence s_rd(a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	// Access edge of a write to the ring mode word
	sequence s_wr_mode;
		psel && penable && pwrite && paddr == 12'h048;
	endsequence
	// Dropout steady long enough to cross the synchroniser
	sequence s_drop_calm;
		$stable(line_dropout_in) [*4];
	endsequence
	a_bus_ready: assert property (pready && !pslverr)
		else $error("bus not ready");
	a_reset_quiet: assert property ($rose(presetn) |->
		!ring_fullwave_select && !ring_detect_flag && call_progress_output == 0)
		else $error("reset values");
	a_mode_write: assert property (s_wr_mode |=> ring_fullwave_select == $past(pwdata[1]))
		else $error("mode write");
	a_mode_hold: assert property (!(psel && penable && pwrite && paddr == 12'h048)
		|=> $stable(ring_fullwave_select))
		else $error("mode changed alone");
	a_mode_read: assert property (s_rd(12'h048) |=> prdata == {30'h0, ring_fullwave_select, 1'b0})
		else $error("mode read");
	a_drop_read: assert property (s_drop_calm ##0 s_rd(12'h04c)
		|=> prdata == {30'h0, $past(line_dropout_in), 1'b0})
		else $error("dropout read");
	a_gap_read: assert property (s_rd(12'h064) |=> prdata == 32'h0)
		else $error("unmapped read");
	a_upper_zero: assert property (psel && !penable && !pwrite |=> prdata[31:8] == 24'h0)
		else $error("upper bits");
endmodule // drm_regs_chk

bind drm_regs drm_regs_chk #(.SAMPLE_W(SAMPLE_W)) chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
	.line_dropout_in, .ring_detect_flag, .ring_fullwave_select, .call_progress_output
);

// File: testbench/tb_daa_ring_callprog_regs.sv
// Self-checking bench for the ring mode, dropout and monitor bank.
// Assumes drm_regs, its checker and the host model compiled first.
`timescale 1ns/1ps
module tb_daa_ring_callprog_regs;
	// Stimulus: ring_in is threshold, envelope, fullwave, halfwave
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg [3:0] ring_in = 4'h0;
	reg drop_in = 1'b0;
	reg [15:0] rx_sample = 16'h1000;
	reg [15:0] tx_sample = 16'h0800;
	wire psel, penable, pwrite, pready, pslverr, irq, ring_detect_flag, ring_fullwave_select;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [15:0] call_progress_output;
	// Rows: address, write data, read back, monitor output
	reg [43:0] rows [0:9];
	reg [31:0] q;
	integer n_fail = 0;
	integer compares = 0;
	integer i;
	always #10 pclk = ~pclk;
	drm_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata);
	drm_regs #(.ONESHOT_CYCLES(28'd20)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .ring_halfwave_in(ring_in[0]), .ring_fullwave_in(ring_in[1]),
		.ring_envelope_in(ring_in[2]), .ring_threshold_in(ring_in[3]),
		.line_dropout_in(drop_in), .rx_sample, .tx_sample, .ring_detect_flag,
		.ring_fullwave_select, .call_progress_output, .irq
	);
	// ------
	// Checking and closing
	// ------
	task chk(input [8*8:1] what, input [31:0] exp, input [31:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// Watchdog: the run needs under 1000 cycles
	initial begin
		#100000;
		n_fail = n_fail + 1;
		tally_and_finish;
	end
	initial begin
		rows[0] = {12'h048, 8'h02, 8'h02, 16'h1800};
		rows[1] = {12'h048, 8'h00, 8'h00, 16'h1800};
		rows[2] = {12'h04c, 8'h02, 8'h00, 16'h1800};
		rows[3] = {12'h064, 8'hff, 8'h00, 16'h1800};
		rows[4] = {12'h050, 8'h7f, 8'h7f, 16'h27c0};
		rows[5] = {12'h050, 8'h20, 8'h20, 16'h1000};
		rows[6] = {12'h050, 8'h00, 8'h00, 16'h0800};
		rows[7] = {12'h054, 8'h20, 8'h20, 16'h0400};
		rows[8] = {12'h054, 8'h10, 8'h10, 16'h0200};
		rows[9] = {12'h054, 8'h00, 8'h00, 16'h0000};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 10; i = i + 1) begin
			host.xfer(1'b1, rows[i][43:32], {24'h0, rows[i][31:24]}, q);
			host.xfer(1'b0, rows[i][43:32], 32'h0, q);
			chk("readback", {24'h0, rows[i][23:16]}, q);
			chk("monitor", {16'h0, rows[i][15:0]}, {16'h0, call_progress_output});
		end
		// Only the selected indication may reach the flag
		for (i = 0; i < 3; i = i + 1) begin
			host.xfer(1'b1, 12'h048, {30'h0, i == 1, 1'b0}, q);
			host.xfer(1'b1, 12'h058, {31'h0, i == 2}, q);
			ring_in <= 4'h7 ^ (4'h1 << i);
			repeat (6) @(posedge pclk);
			chk("flag", 32'h0, {31'h0, ring_detect_flag});
			ring_in <= 4'h1 << i;
			repeat (6) @(posedge pclk);
			chk("flag", 32'h1, {31'h0, ring_detect_flag});
		end
		// One-shot ignores a retrigger and ends only at its timeout
		ring_in <= 4'h0;
		repeat (6) @(posedge pclk);
		host.xfer(1'b1, 12'h048, 32'h2, q);
		ring_in <= 4'h8;
		repeat (5) @(posedge pclk);
		chk("oneshot", 32'h1, {31'h0, ring_detect_flag});
		ring_in <= 4'h0;
		repeat (4) @(posedge pclk);
		ring_in <= 4'h8;
		repeat (8) @(posedge pclk);
		chk("oneshot", 32'h1, {31'h0, ring_detect_flag});
		repeat (12) @(posedge pclk);
		chk("oneshot", 32'h0, {31'h0, ring_detect_flag});
		// Dropout, then its interrupt unmasked, cleared and the status read back
		drop_in <= 1'b1;
		repeat (4) @(posedge pclk);
		host.xfer(1'b0, 12'h04c, 32'h0, q);
		chk("dropout", 32'h2, q);
		host.xfer(1'b1, 12'h060, 32'h2, q);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		host.xfer(1'b1, 12'h05c, 32'h2, q);
		#1;
		chk("irq", 32'h0, {31'h0, irq});
		host.xfer(1'b0, 12'h05c, 32'h0, q);
		chk("status", 32'h5, q);
		// Reset in mid-run restores the defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		host.xfer(1'b0, 12'h048, 32'h0, q);
		chk("mode", 32'h0, q);
		host.xfer(1'b0, 12'h050, 32'h0, q);
		chk("rxlevel", 32'h40, q);
		chk("monitor", 32'h1800, {16'h0, call_progress_output});
		chk("irq", 32'h0, {31'h0, irq});
		tally_and_finish;
	end
endmodule // tb_daa_ring_callprog_regs
